/* File: inc/spg_consts.vh */
`ifndef SPG_CONSTS_VH
`define SPG_CONSTS_VH
// ****************************************
// address map, byte offsets from block base
// ****************************************
`define SPG_BASE_ADDR     32'h4000E000
`define SPG_ADDR_W        12
`define SPG_OFF_GLOBAL    12'h000
`define SPG_OFF_CTRL0     12'h004
`define SPG_OFF_LIM0      12'h008
`define SPG_OFF_CTRL_LAST 12'h02C
`define SPG_OFF_LIM_LAST  12'h030
`define SPG_OFF_STATUS    12'h034
`define SPG_CH_SHIFT      3
// ****************************************
// field positions
// ****************************************
`define SPG_GLB_GATE_A    0
`define SPG_GLB_GATE_B    4
`define SPG_CTL_EN        0
`define SPG_CTL_LOAD      1
`define SPG_CTL_POL       2
`define SPG_CTL_MODE      3
`define SPG_CTL_PRE_LO    4
`define SPG_CTL_PRE_HI    6
`define SPG_CTL_W         7
`define SPG_LIM_THR_LO    0
`define SPG_LIM_THR_HI    15
`define SPG_LIM_TOP_LO    16
`define SPG_LIM_TOP_HI    31
`define SPG_STS_EN_LO     8
// ****************************************
// reset values
// ****************************************
`define SPG_GLB_RST       32'h00000000
`define SPG_CTL_RST       7'h00
`define SPG_TOP_RST       16'hFFFF
`define SPG_THR_RST       16'h0000
`define SPG_PRE_MAX       3'h6
`endif

/* File: rtl/spg_prescale.v */
`include "spg_consts.vh"
`default_nettype none
// ****************************************
// power-of-two clock prescaler
// ****************************************
module spg_prescale (
   input  wire       clk,
   input  wire       sys_rst,
   input  wire       run,
   input  wire [2:0] sel,
   output reg        tick
);
   reg  [6:0] div_r;
   wire [2:0] sel_lim;
   wire [6:0] mask;

   assign sel_lim = (sel > `SPG_PRE_MAX) ? `SPG_PRE_MAX : sel;
   // ratio two to k plus one
   assign mask    = ~(7'h7F << (sel_lim + 3'h1));

   always @(posedge clk) begin
      if (sys_rst || !run) begin
         div_r <= 7'h00;
         tick  <= 1'b0;
      end else begin
         div_r <= div_r + 7'h01;
         tick  <= ((div_r & mask) == mask);
      end
   end
endmodule // spg_prescale
`default_nettype wire

/* File: rtl/spg_channel.v */
`include "spg_consts.vh"
`default_nettype none
// ****************************************
// one pwm counter and output stage
// ****************************************
module spg_channel (
   input  wire        clk,
   input  wire        sys_rst,
   input  wire        en,
   input  wire        ld,
   input  wire        tick,
   input  wire [15:0] top_in,
   input  wire [15:0] thr_in,
   input  wire        pol_in,
   input  wire        mode_in,
   input  wire [2:0]  pre_in,
   output reg  [2:0]  pre_act,
   output reg         pwm,
   output reg  [15:0] cnt_r
);
   reg        dir_down_r;
   reg [15:0] top_r;
   reg [15:0] thr_r;
   reg        pol_r;
   reg        mode_r;
   reg [15:0] cnt_nxt;
   reg        dir_nxt;
   reg        bound;

   always @* begin
      cnt_nxt = cnt_r;
      dir_nxt = dir_down_r;
      bound   = 1'b0;
      if (tick) begin
         if (!mode_r) begin
            if (cnt_r + 16'h0001 >= top_r) begin
               cnt_nxt = 16'h0000;
               bound   = 1'b1;
            end else begin
               cnt_nxt = cnt_r + 16'h0001;
            end
         end else if (!dir_down_r) begin
            if (cnt_r >= top_r) begin
               cnt_nxt = (top_r == 16'h0000) ? 16'h0000 : cnt_r - 16'h0001;
               dir_nxt = 1'b1;
               bound   = 1'b1;
            end else begin
               cnt_nxt = cnt_r + 16'h0001;
            end
         end else begin
            if (cnt_r <= 16'h0001) begin
               cnt_nxt = 16'h0000;
               dir_nxt = 1'b0;
               bound   = 1'b1;
            end else begin
               cnt_nxt = cnt_r - 16'h0001;
            end
         end
      end
   end

   always @(posedge clk) begin
      if (sys_rst) begin
         cnt_r      <= 16'h0000;
         dir_down_r <= 1'b0;
         top_r      <= `SPG_TOP_RST;
         thr_r      <= `SPG_THR_RST;
         pol_r      <= 1'b0;
         mode_r     <= 1'b0;
         pre_act    <= 3'h0;
         pwm        <= 1'b1;
      end else begin
         if (ld && (bound || !en)) begin
            top_r   <= top_in;
            thr_r   <= thr_in;
            pol_r   <= pol_in;
            mode_r  <= mode_in;
            pre_act <= pre_in;
         end
         if (!en) begin
            cnt_r      <= 16'h0000;
            dir_down_r <= 1'b0;
            pwm        <= ~pol_r;
         end else begin
            cnt_r      <= cnt_nxt;
            dir_down_r <= dir_nxt;
            pwm        <= (cnt_r < thr_r) ? pol_r : ~pol_r;
         end
      end
   end
endmodule // spg_channel
`default_nettype wire

/* File: rtl/spg_pwm_top.v */
// Implementation choice: strobed register access.
`include "spg_consts.vh"
`default_nettype none
// ****************************************
// six channel pwm generator
// ****************************************
// What this block does
// - six independent channels, own outputs
// - prescaler divides clock, 2 to 128
// - prescaler select is three bits
// - up mode counts zero to limit minus one
// - period is ratio times limit in up mode, twice that in up/down mode
// - output changes at threshold
// - polarity picks level below threshold
// - up/down mode counts back down
// - per channel enable
// - load enable applies new settings
// - channel registers at E004 to E030
module spg_pwm_top #(
   parameter NCH = 6
) (
   input  wire                   clk,
   input  wire                   sys_rst,
   input  wire [`SPG_ADDR_W-1:0] bus_addr,
   input  wire [31:0]            bus_wdata,
   input  wire                   bus_wr,
   input  wire                   bus_rd,
   output reg  [31:0]            bus_rdata,
   output reg  [NCH-1:0]         pwm_out,
   output reg  [NCH-1:0]         pwm_oe
);
   // ****************************************
   // address decode helpers
   // ****************************************
   function [2:0] ch_of;
      input [`SPG_ADDR_W-1:0] a;
      reg   [`SPG_ADDR_W-1:0] d;
      begin
         d     = a - `SPG_OFF_CTRL0;
         ch_of = d[`SPG_CH_SHIFT+2:`SPG_CH_SHIFT];
      end
   endfunction

   function is_ctrl;
      input [`SPG_ADDR_W-1:0] a;
      begin
         is_ctrl = (a >= `SPG_OFF_CTRL0) && (a <= `SPG_OFF_CTRL_LAST)
                   && (a[2:0] == 3'h4);
      end
   endfunction

   function is_lim;
      input [`SPG_ADDR_W-1:0] a;
      begin
         is_lim = (a >= `SPG_OFF_LIM0) && (a <= `SPG_OFF_LIM_LAST)
                  && (a[2:0] == 3'h0);
      end
   endfunction

   // ****************************************
   // register storage
   // ****************************************
   reg  [31:0]            glb_r;
   reg  [`SPG_CTL_W-1:0]  ctl_r [0:NCH-1];
   reg  [31:0]            lim_r [0:NCH-1];
   reg  [31:0]            rd_nxt;
   wire                   gate_open;
   wire [2:0]             wr_ch;
   wire [NCH-1:0]         pwm_raw;
   wire [NCH-1:0]         en_vec;
   integer                i;

   // channel writes gated by global bits
   assign gate_open = glb_r[`SPG_GLB_GATE_A] & glb_r[`SPG_GLB_GATE_B];
   assign wr_ch     = ch_of(bus_addr);

   // ****************************************
   // register writes
   // ****************************************
   always @(posedge clk) begin
      if (sys_rst) begin
         glb_r <= `SPG_GLB_RST;
         for (i = 0; i < NCH; i = i + 1) begin
            ctl_r[i] <= `SPG_CTL_RST;
            lim_r[i] <= {`SPG_TOP_RST, `SPG_THR_RST};
         end
      end else if (bus_wr) begin
         if (bus_addr == `SPG_OFF_GLOBAL) begin
            glb_r <= bus_wdata;
         end
         if (gate_open && is_ctrl(bus_addr) && (wr_ch < NCH)) begin
            ctl_r[wr_ch] <= bus_wdata[`SPG_CTL_W-1:0];
         end
         if (gate_open && is_lim(bus_addr) && (wr_ch < NCH)) begin
            lim_r[wr_ch] <= bus_wdata;
         end
      end
   end

   // ****************************************
   // register reads
   // ****************************************
   always @* begin
      rd_nxt = 32'h00000000;
      if (bus_addr == `SPG_OFF_GLOBAL) begin
         rd_nxt = glb_r;
      end else if (bus_addr == `SPG_OFF_STATUS) begin
         rd_nxt[NCH-1:0] = pwm_raw;
         rd_nxt[`SPG_STS_EN_LO+NCH-1:`SPG_STS_EN_LO] = en_vec;
      end else if (is_ctrl(bus_addr) && (wr_ch < NCH)) begin
         rd_nxt[`SPG_CTL_W-1:0] = ctl_r[wr_ch];
      end else if (is_lim(bus_addr) && (wr_ch < NCH)) begin
         rd_nxt = lim_r[wr_ch];
      end
   end

   always @(posedge clk) begin
      if (sys_rst) begin
         bus_rdata <= 32'h00000000;
      end else if (bus_rd) begin
         bus_rdata <= rd_nxt;
      end else begin
         bus_rdata <= 32'h00000000;
      end
   end

   // ****************************************
   // channels
   // ****************************************
   genvar g;
   generate
      for (g = 0; g < NCH; g = g + 1) begin : g_ch
         wire       tick;
         wire [2:0] pre_act;
         wire [6:0] ctl;

         assign ctl       = ctl_r[g];
         assign en_vec[g] = ctl[`SPG_CTL_EN];

         // tick rate times limit sets period
         spg_prescale u_pre (
            .clk     (clk),
            .sys_rst (sys_rst),
            .run     (ctl[`SPG_CTL_EN]),
            .sel     (pre_act),
            .tick    (tick)
         );

         spg_channel u_chan (
            .clk     (clk),
            .sys_rst (sys_rst),
            .en      (ctl[`SPG_CTL_EN]),
            .ld      (ctl[`SPG_CTL_LOAD]),
            .tick    (tick),
            .top_in  (lim_r[g][`SPG_LIM_TOP_HI:`SPG_LIM_TOP_LO]),
            .thr_in  (lim_r[g][`SPG_LIM_THR_HI:`SPG_LIM_THR_LO]),
            .pol_in  (ctl[`SPG_CTL_POL]),
            .mode_in (ctl[`SPG_CTL_MODE]),
            .pre_in  (ctl[`SPG_CTL_PRE_HI:`SPG_CTL_PRE_LO]),
            .pre_act (pre_act),
            .pwm     (pwm_raw[g]),
            .cnt_r   ()
         );
      end
   endgenerate

   // ****************************************
   // pad outputs
   // ****************************************
   always @(posedge clk) begin
      if (sys_rst) begin
         pwm_out <= {NCH{1'b1}};
         pwm_oe  <= {NCH{1'b0}};
      end else begin
         pwm_out <= pwm_raw;
         pwm_oe  <= en_vec;
      end
   end
endmodule // spg_pwm_top
`default_nettype wire

/* File: tb/spg_pwm_asserts.sv */
`default_nettype none
// ****************************************
// port checker for the pwm generator
// ****************************************
module spg_pwm_asserts #(
   parameter NCH = 6
) (
   input wire logic             clk,
   input wire logic             sys_rst,
   input wire logic [11:0]      bus_addr,
   input wire logic [31:0]      bus_wdata,
   input wire logic             bus_wr,
   input wire logic             bus_rd,
   input wire logic [31:0]      bus_rdata,
   input wire logic [NCH-1:0]   pwm_out,
   input wire logic [NCH-1:0]   pwm_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic gate_r;
   // tracks whether both global gating bits are set
   always_ff @(posedge clk) begin
      if (sys_rst)
         gate_r <= 1'b0;
      else if (bus_wr && bus_addr == 12'h000)
         gate_r <= bus_wdata[0] & bus_wdata[4];
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   chk_rdata_idle: assert property (
      !$past(bus_rd) |-> bus_rdata == 32'h0) else $error("read data not idle");
   chk_unmapped_zero: assert property (
      bus_rd && bus_addr >= 12'h038 |=> bus_rdata == 32'h0) else $error("unmapped read");
   chk_en_to_oe: assert property (
      gate_r && bus_wr && bus_addr == 12'h004 |-> ##2 pwm_oe[0] == $past(bus_wdata[0], 2))
      else $error("enable not on pad enable");
   chk_gate_refuse: assert property (
      !gate_r && bus_wr && bus_addr == 12'h004 |-> ##2 pwm_oe == $past(pwm_oe, 2))
      else $error("gated write took effect");
   chk_status_oe: assert property (
      bus_rd && bus_addr == 12'h034 |=> bus_rdata[13:8] == pwm_oe) else $error("status enables");
   chk_status_raw: assert property (
      bus_rd && bus_addr == 12'h034 |=> bus_rdata[5:0] == pwm_out) else $error("status outputs");
   chk_glb_readback: assert property (
      bus_wr && bus_addr == 12'h000 ##1 !bus_wr ##1 bus_rd && bus_addr == 12'h000
      |=> {bus_rdata[4], bus_rdata[0]} == {$past(bus_wdata[4], 3), $past(bus_wdata[0], 3)})
      else $error("global readback");
   chk_reset_state: assert property (disable iff (1'b0)
      sys_rst |=> pwm_oe == '0 && pwm_out == '1 && bus_rdata == 32'h0) else $error("reset state");
   cover property (gate_r && bus_wr && bus_addr == 12'h004);
   cover property (bus_rd && bus_addr == 12'h034);
   cover property (pwm_oe[0] && $rose(pwm_out[0]));
endmodule // spg_pwm_asserts

bind spg_pwm_top spg_pwm_asserts #(.NCH(NCH)) u_chk (.clk(clk), .sys_rst(sys_rst),
   .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
   .bus_rdata(bus_rdata), .pwm_out(pwm_out), .pwm_oe(pwm_oe));
`default_nettype wire

/* File: tb/spg_pwm_top_tb.sv */
`default_nettype none
// ****************************************
// pwm generator testbench
// ****************************************
module spg_pwm_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic [11:0] bus_addr = 12'h000;
   logic [31:0] bus_wdata = 32'h0;
   logic        bus_wr = 1'b0;
   logic        bus_rd = 1'b0;
   wire  [31:0] bus_rdata;
   wire  [5:0]  pwm_out;
   wire  [5:0]  pwm_oe;
   int          fails = 0;
   int          checks = 0;
   always #5 clk = ~clk;
   spg_pwm_top #(.NCH(6)) u_dut (.clk(clk), .sys_rst(sys_rst), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
      .pwm_out(pwm_out), .pwm_oe(pwm_oe));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge clk);
      bus_wr <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      @(posedge clk);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge clk);
      bus_rd <= 1'b0;
      #1;
      check(bus_rdata, exp);
   endtask
   task automatic cfg(input int ch, input logic [31:0] c, input logic [31:0] l);
      wr(12'(4 + 8 * ch), 32'h2);
      wr(12'(8 + 8 * ch), l);
      wr(12'(4 + 8 * ch), c);
   endtask
   // counts high samples and rising edges of one output
   task automatic meas(input int ch, input int n, input int ones, input int rises);
      int   o;
      int   r;
      logic p;
      o = 0;
      r = 0;
      @(posedge clk);
      #1;
      p = pwm_out[ch];
      repeat (n) begin
         @(posedge clk);
         #1;
         o += pwm_out[ch];
         r += (pwm_out[ch] && !p);
         p = pwm_out[ch];
      end
      check(o, ones);
      check(r, rises);
   endtask
   task automatic tally_and_finish;
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      tally_and_finish;
   end
   initial begin
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      #1;
      check(pwm_out, 32'h3F);
      check(pwm_oe, 32'h0);
      rd(12'h008, 32'hFFFF0000);
      rd(12'h034, 32'h3F);
      rd(12'h040, 32'h0);
      rd(12'h100, 32'h0);
      $display("test reset done");
      wr(12'h004, 32'h1);
      rd(12'h004, 32'h0);
      wr(12'h000, 32'h01);
      wr(12'h004, 32'h1);
      rd(12'h004, 32'h0);
      wr(12'h000, 32'h11);
      rd(12'h000, 32'h11);
      $display("test gating done");
      for (int n = 0; n < 6; n++) begin
         cfg(n, 32'h7, {16'(n + 2), 16'h1});
         rd(12'(4 + 8 * n), 32'h7);
         rd(12'(8 + 8 * n), {16'(n + 2), 16'h1});
      end
      check(pwm_oe, 32'h3F);
      for (int n = 0; n < 6; n++) begin
         meas(n, 4 * (n + 2), 4, 2);
      end
      $display("test six channels done");
      for (int k = 0; k < 7; k++) begin
         cfg(0, 32'h7 | (k << 4), {16'd3, 16'd1});
         repeat ((3 << (k + 1)) + 8) @(posedge clk);
         meas(0, 6 << (k + 1), 2 << (k + 1), 2);
      end
      $display("test prescaler done");
      cfg(0, 32'hB, {16'd3, 16'd1});
      repeat (12) @(posedge clk);
      meas(0, 24, 20, 2);
      wr(12'h004, 32'h9);
      wr(12'h008, {16'd3, 16'd2});
      meas(0, 24, 20, 2);
      wr(12'h004, 32'hB);
      repeat (12) @(posedge clk);
      meas(0, 24, 12, 2);
      $display("test load and updown done");
      wr(12'h004, 32'h6);
      repeat (4) @(posedge clk);
      #1;
      check(pwm_out[0], 32'h0);
      check(pwm_oe, 32'h3E);
      for (int n = 1; n < 6; n++) begin
         cfg(n, 32'h7, {16'(n + 2), 16'h0});
      end
      repeat (24) @(posedge clk);
      #1;
      check(pwm_out, 32'h0);
      rd(12'h034, 32'h3E00);
      $display("test disable done");
      @(posedge clk);
      sys_rst <= 1'b1;
      @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      #1;
      check(pwm_out, 32'h3F);
      check(pwm_oe, 32'h0);
      rd(12'h004, 32'h0);
      $display("test mid-run reset done");
      tally_and_finish;
   end
endmodule // spg_pwm_top_tb
`default_nettype wire
